// File: verilog/aso_servo_io.sv
// Contract
// - Auto servo-off drops servo a set delay after positioning ends.
// - Next move command wakes an auto-off servo, then moves.
// - Separate forward and backward delays.
// - Delays in 0.1 s steps from 0.0 to 9,999.9 s.
// - Zero delay disables it for that direction.
// - After a push, auto-off waits for command release.
// - Only a missed push counts as completion for auto-off.
// - New delays apply only after reset or software reset; the code loads them only on software reset, and reset clears them to 0.
// - No auto servo-off in teaching mode.
// - Retract drives backward.
// - Extend drives forward.
// - Release mid-move gives a decelerated stop.
// - Command before homing runs home return first.
// - Alarm clear resets the alarm.
// - Brake released while its input is on.
// - Backward-end output in the backward detection range.
// - Forward-end output in the forward detection range.
// - Pressing mode: push-done output replaces the end output.
// - Alarm output high when healthy, low on alarm.
// - After command homing, continue to the commanded end.
// - Held command moves to the end.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module aso_servo_io
    import aso_pkg::*;
#(
    parameter int TICK_CYCLES = ASO_TICK_CYC
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Master device discrete inputs
    input  wire logic        retract_command,
    input  wire logic        extend_command,
    input  wire logic        alarm_clear_input,
    input  wire logic        brake_release_input,
    // Motion core
    input  wire aso_fb_t     motion_fb,
    output var  aso_drive_t  drive_q,
    output var  logic        servo_on_q,
    output var  logic        brake_release_q,
    // Master device discrete outputs
    output var  logic        backward_end_reached,
    output var  logic        forward_end_reached,
    output var  logic        backward_push_done,
    output var  logic        forward_push_done,
    output var  logic        alarm_ok_n
);

    // ==========
    // Declarations
    aso_state_t             state_q;
    logic [4:0]             ctrl_q;
    logic [ASO_DLY_W-1:0]   dly_fwd_q;
    logic [ASO_DLY_W-1:0]   dly_bwd_q;
    logic [ASO_DLY_W-1:0]   act_fwd_q;
    logic [ASO_DLY_W-1:0]   act_bwd_q;
    logic                   soft_rst_q;
    logic                   homed_q;
    logic                   alarm_q;
    logic                   auto_off_q;
    logic                   dir_q;
    logic                   pend_q;
    logic                   pend_hold_q;
    logic                   retract_prev_q;
    logic                   extend_prev_q;
    logic                   clear_prev_q;
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [3:0]             aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   tick;
    logic                   expired;
    logic                   new_cmd;
    logic                   new_dir;
    logic                   cmd_held;
    logic                   push_dir;
    logic                   at_end;
    logic                   arm;
    logic                   clear_edge;
    logic                   wr_fire;
    logic [ASO_DLY_W-1:0]   sel_dly;

    function automatic logic mapped(input logic [3:0] a);
        return a == ASO_REG_CTRL || a == ASO_REG_DLY_FWD ||
               a == ASO_REG_DLY_BWD || a == ASO_REG_STATUS;
    endfunction

    function automatic logic [ASO_DLY_W-1:0] clamp_dly(input logic [31:0] v);
        return (v > 32'(ASO_DLY_MAX)) ? ASO_DLY_MAX : v[ASO_DLY_W-1:0];
    endfunction

    // ==========
    // Command decode
    // one direction at a time
    assign new_dir  = extend_command & ~extend_prev_q;
    assign new_cmd  = ((retract_command & ~retract_prev_q) | (extend_command & ~extend_prev_q))
                      & ~(retract_command & extend_command);
    assign cmd_held = dir_q ? extend_command : retract_command;
    assign push_dir = dir_q ? ctrl_q[ASO_CTRL_PUSH_FWD] : ctrl_q[ASO_CTRL_PUSH_BWD];
    assign at_end   = push_dir ? (motion_fb.push_contact | motion_fb.push_missed)
                               : (dir_q ? motion_fb.in_fwd_range : motion_fb.in_bwd_range);
    assign clear_edge = alarm_clear_input & ~clear_prev_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            retract_prev_q <= 1'b0;
            extend_prev_q  <= 1'b0;
            clear_prev_q   <= 1'b0;
        end
        else
        begin
            retract_prev_q <= retract_command;
            extend_prev_q  <= extend_command;
            clear_prev_q   <= alarm_clear_input;
        end
    end

    // ==========
    // Motion sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst_q)
        begin
            state_q <= ASO_ST_IDLE;
            dir_q   <= 1'b0;
            homed_q <= 1'b0;
        end
        else if (alarm_q)
            state_q <= (state_q == ASO_ST_IDLE) ? ASO_ST_IDLE : ASO_ST_DECEL;
        else
        begin
            unique case (state_q)
                ASO_ST_IDLE:
                    if (new_cmd)
                    begin
                        dir_q <= new_dir;
                        if (!servo_on_q)
                            state_q <= ASO_ST_WAKE;
                        else if (!homed_q)
                            state_q <= ASO_ST_HOME;
                        else
                            state_q <= ASO_ST_MOVE;
                    end
                ASO_ST_WAKE:
                    state_q <= homed_q ? ASO_ST_MOVE : ASO_ST_HOME;
                ASO_ST_HOME:
                    if (!cmd_held)
                        state_q <= ASO_ST_DECEL;
                    else if (motion_fb.home_done)
                    begin
                        homed_q <= 1'b1;
                        state_q <= ASO_ST_MOVE;
                    end
                ASO_ST_MOVE:
                    if (!cmd_held)
                        state_q <= ASO_ST_DECEL;
                    else if (at_end)
                        state_q <= ASO_ST_IDLE;
                ASO_ST_DECEL:
                    if (motion_fb.stopped)
                        state_q <= ASO_ST_IDLE;
                default:
                    state_q <= ASO_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            drive_q <= '0;
        else
        begin
            drive_q.run_bwd  <= (state_q == ASO_ST_MOVE) && !dir_q && !alarm_q;
            drive_q.run_fwd  <= (state_q == ASO_ST_MOVE) && dir_q && !alarm_q;
            drive_q.home_run <= (state_q == ASO_ST_HOME) && !alarm_q;
            drive_q.decel    <= (state_q == ASO_ST_DECEL);
        end
    end

    // ==========
    // Automatic servo-off
    // per-direction delay
    assign sel_dly = dir_q ? act_fwd_q : act_bwd_q;
    // wait for command release after push
    assign arm = pend_q && (state_q == ASO_ST_IDLE) && servo_on_q
                 && ctrl_q[ASO_CTRL_AUTO_EN] && !ctrl_q[ASO_CTRL_TEACH]
                 && (sel_dly != '0) && !(pend_hold_q && cmd_held);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst_q || new_cmd)
        begin
            pend_q      <= 1'b0;
            pend_hold_q <= 1'b0;
        end
        else if (state_q == ASO_ST_MOVE && cmd_held && at_end)
        begin
            pend_q      <= !(push_dir && motion_fb.push_contact);
            pend_hold_q <= push_dir;
        end
        else if (expired)
            pend_q <= 1'b0;
    end

    aso_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    aso_off_timer #(
        .DLY_W (ASO_DLY_W)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (new_cmd),
        .arm     (arm),
        .tick    (tick),
        .delay   (sel_dly),
        .expired (expired)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst_q)
        begin
            servo_on_q <= 1'b1;
            auto_off_q <= 1'b0;
        end
        else if (alarm_q && (motion_fb.fault || !clear_edge))
        begin
            servo_on_q <= 1'b0;
            auto_off_q <= 1'b0;
        end
        else if (state_q == ASO_ST_WAKE || (clear_edge && !servo_on_q && !auto_off_q))
        begin
            servo_on_q <= 1'b1;
            auto_off_q <= 1'b0;
        end
        else if (expired && arm)
        begin
            servo_on_q <= 1'b0;
            auto_off_q <= 1'b1;
        end
    end

    // ==========
    // Alarm, brake and end outputs
    // clear, but a new fault wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst_q)
            alarm_q <= 1'b0;
        else if (motion_fb.fault)
            alarm_q <= 1'b1;
        else if (clear_edge)
            alarm_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_ok_n           <= 1'b0;
            brake_release_q      <= 1'b0;
            backward_end_reached <= 1'b0;
            forward_end_reached  <= 1'b0;
            backward_push_done   <= 1'b0;
            forward_push_done    <= 1'b0;
        end
        else
        begin
            alarm_ok_n           <= !alarm_q && !motion_fb.fault;
            brake_release_q      <= brake_release_input;
            backward_end_reached <= !ctrl_q[ASO_CTRL_PUSH_BWD] && motion_fb.in_bwd_range;
            forward_end_reached  <= !ctrl_q[ASO_CTRL_PUSH_FWD] && motion_fb.in_fwd_range;
            if (new_cmd || state_q != ASO_ST_IDLE && state_q != ASO_ST_MOVE)
            begin
                backward_push_done <= 1'b0;
                forward_push_done  <= 1'b0;
            end
            else if (state_q == ASO_ST_MOVE && push_dir && motion_fb.push_contact)
            begin
                backward_push_done <= !dir_q;
                forward_push_done  <= dir_q;
            end
        end
    end

    // ==========
    // Register file
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q     <= ASO_CTRL_RESET;
            dly_fwd_q  <= ASO_DLY_RESET;
            dly_bwd_q  <= ASO_DLY_RESET;
            soft_rst_q <= 1'b0;
        end
        else
        begin
            soft_rst_q <= 1'b0;
            if (wr_fire && w_strb_q != 4'h0)
            begin
                unique case (aw_addr_q)
                    ASO_REG_CTRL:
                    begin
                        ctrl_q     <= {1'b0, w_data_q[3:0]};
                        soft_rst_q <= w_data_q[ASO_CTRL_SOFT_RST];
                    end
                    ASO_REG_DLY_FWD: dly_fwd_q <= clamp_dly(w_data_q);
                    ASO_REG_DLY_BWD: dly_bwd_q <= clamp_dly(w_data_q);
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act_fwd_q <= ASO_DLY_RESET;
            act_bwd_q <= ASO_DLY_RESET;
        end
        else if (soft_rst_q)
        begin
            act_fwd_q <= dly_fwd_q;
            act_bwd_q <= dly_bwd_q;
        end
    end

    // ==========
    // AXI4-Lite write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ASO_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_q) ? ASO_RESP_OKAY : ASO_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ==========
    // AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= ASO_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= mapped(s_axi_araddr) ? ASO_RESP_OKAY : ASO_RESP_SLVERR;
                unique case (s_axi_araddr)
                    ASO_REG_CTRL:    s_axi_rdata <= {27'h0, ctrl_q};
                    ASO_REG_DLY_FWD: s_axi_rdata <= {15'h0, dly_fwd_q};
                    ASO_REG_DLY_BWD: s_axi_rdata <= {15'h0, dly_bwd_q};
                    ASO_REG_STATUS:  s_axi_rdata <= {25'h0, state_q, alarm_q, homed_q,
                                                     auto_off_q, servo_on_q};
                    default:         s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // aso_servo_io
`default_nettype wire

// File: verilog/aso_pkg.sv
`default_nettype none
package aso_pkg;

    // ==========
    // Register map (byte addresses)
    localparam logic [3:0] ASO_REG_CTRL    = 4'h0;
    localparam logic [3:0] ASO_REG_DLY_FWD = 4'h4;
    localparam logic [3:0] ASO_REG_DLY_BWD = 4'h8;
    localparam logic [3:0] ASO_REG_STATUS  = 4'hc;

    // ==========
    // Control register fields
    localparam int ASO_CTRL_AUTO_EN  = 0;
    localparam int ASO_CTRL_TEACH    = 1;
    localparam int ASO_CTRL_PUSH_BWD = 2;
    localparam int ASO_CTRL_PUSH_FWD = 3;
    localparam int ASO_CTRL_SOFT_RST = 4;
    localparam logic [4:0] ASO_CTRL_RESET = 5'h00;

    // ==========
    // Status register fields
    localparam int ASO_STAT_SERVO  = 0;
    localparam int ASO_STAT_AUTOFF = 1;
    localparam int ASO_STAT_HOMED  = 2;
    localparam int ASO_STAT_ALARM  = 3;
    localparam int ASO_STAT_STATE  = 4;

    // ==========
    // Delay setting: 0.1 s steps, 0.0 .. 9,999.9 s
    localparam int                ASO_DLY_W     = 17;
    localparam logic [16:0]       ASO_DLY_MAX   = 17'h1869f;
    localparam logic [16:0]       ASO_DLY_RESET = 17'h00000;

    // ==========
    // Timebase
    localparam longint ASO_CLK_PERIOD_NS = 20;
    localparam longint ASO_TICK_NS       = 100000000;
    localparam int     ASO_TICK_CYC      = int'(ASO_TICK_NS / ASO_CLK_PERIOD_NS);

    // ==========
    // AXI responses
    localparam logic [1:0] ASO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ASO_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ASO_ST_IDLE  = 3'b000,
        ASO_ST_WAKE  = 3'b001,
        ASO_ST_HOME  = 3'b010,
        ASO_ST_MOVE  = 3'b011,
        ASO_ST_DECEL = 3'b100
    } aso_state_t;

    // Feedback from the motion core
    typedef struct packed {
        logic in_bwd_range;
        logic in_fwd_range;
        logic push_contact;
        logic push_missed;
        logic home_done;
        logic stopped;
        logic fault;
    } aso_fb_t;

    // Orders to the motion core
    typedef struct packed {
        logic run_bwd;
        logic run_fwd;
        logic home_run;
        logic decel;
    } aso_drive_t;

endpackage
`default_nettype wire

// File: verilog/aso_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module aso_tick_div
    import aso_pkg::*;
#(
    parameter int CYCLES = ASO_TICK_CYC
)(
    input  wire logic aclk,
    input  wire logic aresetn,
    output var  logic tick
);

    if (CYCLES < 2)
    begin : g_chk
        $error("aso_tick_div: CYCLES must be at least 2");
    end

    logic [31:0] cnt_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end
        else if (cnt_q == 32'(CYCLES - 1))
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end

endmodule // aso_tick_div
`default_nettype wire

// File: verilog/aso_off_timer.sv
`timescale 1ns/10ps
`default_nettype none
module aso_off_timer
    import aso_pkg::*;
#(
    parameter int DLY_W = ASO_DLY_W
)(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clear,
    input  wire logic             arm,
    input  wire logic             tick,
    input  wire logic [DLY_W-1:0] delay,
    output var  logic             expired
);

    if (DLY_W < ASO_DLY_W)
    begin : g_chk
        $error("aso_off_timer: DLY_W too narrow for the delay range");
    end

    logic [DLY_W-1:0] cnt_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear || !arm)
        begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end
        else if (tick && !expired)
        begin
            cnt_q   <= cnt_q + 1'b1;
            expired <= ((cnt_q + 1'b1) >= delay);
        end
    end

endmodule // aso_off_timer
`default_nettype wire

// File: tb/aso_servo_io_checker.sv
`timescale 1ns/10ps
`default_nettype none
module aso_servo_io_checker
    import aso_pkg::*;
#(
    parameter int TICK_CYCLES = 10
)(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       retract_command,
    input wire logic       extend_command,
    input wire logic       alarm_clear_input,
    input wire logic       brake_release_input,
    input wire aso_fb_t    motion_fb,
    input wire aso_drive_t drive_q,
    input wire logic       servo_on_q,
    input wire logic       brake_release_q,
    input wire logic       backward_end_reached,
    input wire logic       forward_end_reached,
    input wire logic       backward_push_done,
    input wire logic       alarm_ok_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // Multi-step requests
    sequence s_wake;
        !servo_on_q && alarm_ok_n && $rose(extend_command) && !retract_command;
    endsequence
    sequence s_clear;
        $rose(alarm_clear_input) && !motion_fb.fault ##1 !motion_fb.fault;
    endsequence
    a_servo_wake: assert property (s_wake |-> ##[1:3] servo_on_q) else $error("no wake");
    a_alarm_clear: assert property (s_clear |-> ##[0:2] alarm_ok_n) else $error("no clear");
    a_bwd_cause: assert property ($rose(drive_q.run_bwd) |-> retract_command) else $error("bwd");
    a_fwd_cause: assert property ($rose(drive_q.run_fwd) |-> extend_command) else $error("fwd");
    a_release_decel: assert property (drive_q.run_bwd && $fell(retract_command) && !motion_fb.in_bwd_range
        |-> ##[1:3] drive_q.decel) else $error("no decel");
    a_bwd_end: assert property ($rose(backward_end_reached) |-> $past(motion_fb.in_bwd_range))
        else $error("bwd end");
    a_fwd_end: assert property ($rose(forward_end_reached) |-> $past(motion_fb.in_fwd_range))
        else $error("fwd end");
    a_push_excl: assert property (backward_push_done |-> !backward_end_reached) else $error("push");
    a_fault_alarm: assert property (motion_fb.fault |=> !alarm_ok_n) else $error("alarm");
    a_brake_follow: assert property ($changed(brake_release_input)
        |=> brake_release_q == $past(brake_release_input)) else $error("brake");
endmodule // aso_servo_io_checker
`default_nettype wire

// File: tb/aso_motion_model.sv
`timescale 1ns/10ps
`default_nettype none
module aso_motion_model
    import aso_pkg::*;
(
    input  wire logic       aclk,
    input  wire aso_drive_t drive,
    input  wire logic       fault,
    output var  aso_fb_t    fb
);
    // Off home at start
    int pos = 4;
    int hcnt = 0;
    always_ff @(posedge aclk)
    begin
        hcnt <= drive.home_run ? hcnt + 1 : 0;
        if (drive.home_run && hcnt == 3)
            pos <= 2;
        else if (drive.run_fwd && pos < 8)
            pos <= pos + 1;
        else if (drive.run_bwd && pos > 0)
            pos <= pos - 1;
    end
    always_comb
    begin
        fb = '0;
        fb.in_bwd_range = pos == 0;
        fb.in_fwd_range = pos == 8;
        fb.push_contact = pos == 8;
        fb.home_done = drive.home_run && hcnt == 3;
        fb.stopped = !(drive.run_bwd || drive.run_fwd || drive.home_run);
        fb.fault = fault;
    end
endmodule // aso_motion_model
`default_nettype wire

// File: tb/tb_actuator_auto_servo_off_io.sv
`timescale 1ns/10ps
`default_nettype none
module tb_actuator_auto_servo_off_io;
    import aso_pkg::*;
    localparam int TC = 10;
    logic        aclk = 1'h0, aresetn = 1'h0, flt = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        retract_command = 1'h0, extend_command = 1'h0;
    logic        alarm_clear_input = 1'h0, brake_release_input = 1'h0;
    aso_fb_t     motion_fb;
    aso_drive_t  drive_q;
    logic        servo_on_q, brake_release_q, backward_end_reached, forward_end_reached;
    logic        backward_push_done, forward_push_done, alarm_ok_n;
    int          miscompares = 0, check_count = 0, i;
    logic [3:0]  ra [4] = '{ASO_REG_CTRL, ASO_REG_DLY_FWD, ASO_REG_DLY_BWD, 4'h2};
    logic [31:0] rw [4] = '{32'hf, 32'h3, 32'h1ffff, 32'h5};
    logic [31:0] rx [4] = '{32'hf, 32'h3, 32'h1869f, 32'h0};
    logic [1:0]  rr [4] = '{ASO_RESP_OKAY, ASO_RESP_OKAY, ASO_RESP_OKAY, ASO_RESP_SLVERR};
    always #10 aclk = ~aclk;
    aso_servo_io #(.TICK_CYCLES(TC)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .retract_command, .extend_command, .alarm_clear_input,
        .brake_release_input, .motion_fb, .drive_q, .servo_on_q, .brake_release_q, .backward_end_reached,
        .forward_end_reached, .backward_push_done, .forward_push_done, .alarm_ok_n);
    aso_motion_model i_motion (.aclk(aclk), .drive(drive_q), .fault(flt), .fb(motion_fb));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    wire logic [7:0] sv = {forward_push_done, alarm_ok_n, drive_q.home_run, drive_q.run_bwd,
        drive_q.decel, forward_end_reached, backward_end_reached, servo_on_q};
    task automatic wt(input int w, input logic l);
        int n;
        for (n = 0; n < 99 && sv[w] !== l; n++)
            @(posedge aclk);
        chk($sformatf("sig%0d", w), {31'h0, l}, {31'h0, sv[w]});
        if (n == 99)
            end_sim();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 99 && !(s_axi_bvalid && s_axi_bready); n++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, e}, {n == 99, 29'h0, s_axi_bresp});
        if (n == 99)
            end_sim();
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 99 && !(s_axi_rvalid && s_axi_rready); n++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {n == 99, 29'h0, s_axi_rresp});
        if (n == 99)
            end_sim();
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 4; i++)
            rd(ra[i], 32'h0, rr[i]);
        rd(ASO_REG_STATUS, 32'h1, ASO_RESP_OKAY);
        for (i = 0; i < 4; i++)
        begin
            wr(ra[i], rw[i], rr[i]);
            rd(ra[i], rx[i], rr[i]);
        end
        $display("test registers done");
        wr(ASO_REG_DLY_BWD, 32'h2, ASO_RESP_OKAY);
        wr(ASO_REG_DLY_FWD, 32'h0, ASO_RESP_OKAY);
        wr(ASO_REG_CTRL, 32'h11, ASO_RESP_OKAY);
        wr(ASO_REG_DLY_FWD, 32'h1, ASO_RESP_OKAY);
        retract_command <= 1'h1;
        wt(5, 1'h1);
        wt(4, 1'h1);
        wt(1, 1'h1);
        repeat (5) @(posedge aclk);
        chk("servo", 32'h1, {31'h0, servo_on_q});
        wt(0, 1'h0);
        retract_command <= 1'h0;
        @(posedge aclk);
        extend_command <= 1'h1;
        wt(0, 1'h1);
        wt(2, 1'h1);
        repeat (60) @(posedge aclk);
        chk("servo", 32'h1, {31'h0, servo_on_q});
        extend_command <= 1'h0;
        @(posedge aclk);
        retract_command <= 1'h1;
        wt(4, 1'h1);
        retract_command <= 1'h0;
        wt(3, 1'h1);
        $display("test motion done");
        flt <= 1'h1;
        @(posedge aclk);
        flt <= 1'h0;
        wt(6, 1'h0);
        alarm_clear_input <= 1'h1;
        wt(6, 1'h1);
        wt(0, 1'h1);
        brake_release_input <= 1'h1;
        repeat (2) @(posedge aclk);
        chk("brake", 32'h1, {31'h0, brake_release_q});
        $display("test alarm and brake done");
        wr(ASO_REG_CTRL, 32'h19, ASO_RESP_OKAY);
        extend_command <= 1'h1;
        wt(7, 1'h1);
        repeat (30) @(posedge aclk);
        chk("fend", 32'h0, {31'h0, forward_end_reached});
        wt(0, 1'h1);
        $display("test push done");
        end_sim();
    end
endmodule // tb_actuator_auto_servo_off_io
bind aso_servo_io aso_servo_io_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.aclk, .aresetn, .retract_command,
    .extend_command, .alarm_clear_input, .brake_release_input, .motion_fb, .drive_q, .servo_on_q,
    .brake_release_q, .backward_end_reached, .forward_end_reached, .backward_push_done, .alarm_ok_n);
`default_nettype wire
